// ===== design/efs_pkg.sv
// constants, types and helpers for the ecg frame stream master port
// assumes a single 100 MHz system clock and a crystal reference sampled by it
package efs_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS   = 10000;            // 100 MHz system clock
	localparam int SCLK_HALF_PS    = 24400;            // half of 2.5 x 8.192 MHz period
	localparam int SEL_HOLD_PS     = 48800;            // select hold after last rising edge
	localparam int SCLK_HALF_CYC   = (SCLK_HALF_PS / CLK_PERIOD_PS < 1) ? 1 :
		SCLK_HALF_PS / CLK_PERIOD_PS;              // rounded down
	localparam int SEL_HOLD_CYC    = (SEL_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int XTAL_PER_FRAME  = 64;               // 8.192 MHz / 128 kHz

	// ----------------------------------------------------------------
	// frame layout
	// ----------------------------------------------------------------
	localparam int WORD_BITS       = 16;
	localparam int ECG_WORDS       = 5;
	localparam int FRAME_WORDS     = ECG_WORDS + 2;    // header, five ecg, crc
	localparam logic [2:0] LAST_WORD = 3'h6;
	localparam logic [3:0] LAST_BIT  = 4'hf;

	// ----------------------------------------------------------------
	// configuration encodings
	// ----------------------------------------------------------------
	localparam int ECG_CONTROL_REGISTER_HP_BIT   = 3;                // high performance enable
	localparam logic [1:0] RATE_2K   = 2'h0;
	localparam logic [1:0] RATE_16K  = 2'h1;
	localparam logic [1:0] RATE_128K = 2'h2;

	typedef struct packed {
		logic [WORD_BITS-1:0]                header;
		logic [ECG_WORDS-1:0][WORD_BITS-1:0] ecg;    // ecg[0] is sent first
		logic [WORD_BITS-1:0]                crc;
	} efs_frame_t;

	typedef enum logic [2:0] {
		EFS_IDLE, EFS_SETUP, EFS_LOW, EFS_HIGH, EFS_HOLD, EFS_GAP
	} efs_state_t;

	// word of a frame in transmit order
	function automatic logic [WORD_BITS-1:0] efs_word(input efs_frame_t f,
		input logic [2:0] idx);
		logic [WORD_BITS-1:0] w;
		w = f.crc;
		if (idx == 3'h0)
			w = f.header;
		else if (idx <= 3'h5)
			w = f.ecg[idx - 3'h1];
		return w;
	endfunction : efs_word

endpackage : efs_pkg

// ===== design/efs_stream_port.sv
// ecg frame stream master: buffers frames, paces them from the crystal and shifts
// them out on a select / clock / data master link
// assumes frames arrive on clk, the crystal reference is asynchronous to clk
`timescale 1ns/1ns

// Overview of operation
// R01: stream frames only at 128 kHz rate
// R02: header, five ecg words, crc, in order
// R03: stream clock from 2.5x crystal timebase; code divides clk by four instead, 25 MHz
// R04: option clear: select held whole packet
// R05: option set: select pulsed per word
// R06: per word: clock high one period between
// R07: data changes on rising stream clock
// R08: only runs with high performance bit set
// R09: select held past final falling edge
// R10: receiver samples on falling edge, select low
// R11: words sent msb first, sixteen clocks
module efs_stream_port
	import efs_pkg::*;
#(
	parameter int DEPTH = 2
)(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       xtal_ref,
	input  wire logic [7:0] ecg_control_register,
	input  wire logic [1:0] frame_rate_sel,
	input  wire logic       per_word_select_option,
	input  wire efs_frame_t frame_in,
	input  wire logic       frame_valid,
	output logic            frame_ready,
	output logic            frame_select_out_n,
	output logic            stream_clock_out,
	output logic            stream_data_out
);

	// ----------------------------------------------------------------
	// reset release and crystal sampling
	// ----------------------------------------------------------------
	logic       rst_meta, rst_sync_b;
	logic       xtal_meta, xtal_sync, xtal_last;
	logic [5:0] xtal_cnt;
	logic       frame_tick;

	// reset deasserts synchronously so no flop leaves reset mid-edge
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			rst_meta   <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_meta   <= 1'b1;
			rst_sync_b <= rst_meta;
		end

	// two stage sampler, edge detect only on the second stage
	always_ff @(posedge clk or negedge rst_sync_b)
		if (!rst_sync_b)
		begin
			xtal_meta <= 1'b0;
			xtal_sync <= 1'b0;
			xtal_last <= 1'b0;
		end
		else
		begin
			xtal_meta <= xtal_ref;
			xtal_sync <= xtal_meta;
			xtal_last <= xtal_sync;
		end

	// frame pacing: one tick per 64 rising crystal edges gives 128 kHz
	always_ff @(posedge clk or negedge rst_sync_b)
		if (!rst_sync_b)
		begin
			xtal_cnt   <= 6'h00;
			frame_tick <= 1'b0;
		end
		else
		begin
			frame_tick <= 1'b0;
			if (xtal_sync && !xtal_last)
			begin
				xtal_cnt <= xtal_cnt + 6'h01;
				frame_tick <= (xtal_cnt == 6'(XTAL_PER_FRAME - 1)); // R01
			end
		end

	// ----------------------------------------------------------------
	// frame buffer
	// ----------------------------------------------------------------
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	efs_frame_t           mem [DEPTH];
	logic [PW-1:0]        wr_ptr, rd_ptr;
	logic [PW:0]          count;
	logic                 push, pop, stream_en, start;
	efs_state_t           state;
	efs_frame_t           cur;

	assign stream_en = ecg_control_register[ECG_CONTROL_REGISTER_HP_BIT] &&
		(frame_rate_sel == RATE_128K);                           // R01 R08
	assign push  = frame_valid && frame_ready;
	// frames paced out while disabled are dropped, so stale data never streams later
	assign pop   = frame_tick && (count != '0) && (state == EFS_IDLE);
	assign start = pop && stream_en;                               // R01 R08

	always_ff @(posedge clk)
		if (push)
			mem[wr_ptr] <= frame_in;

	// pointers wrap at DEPTH; ready is registered from the next occupancy
	always_ff @(posedge clk or negedge rst_sync_b)
		if (!rst_sync_b)
		begin
			wr_ptr      <= '0;
			rd_ptr      <= '0;
			count       <= '0;
			frame_ready <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			count       <= count + (PW+1)'(push) - (PW+1)'(pop);
			frame_ready <= (count + (PW+1)'(push) - (PW+1)'(pop)) < (PW+1)'(DEPTH);
		end

	// ----------------------------------------------------------------
	// stream clock timebase
	// ----------------------------------------------------------------
	logic [2:0] half_cnt;
	logic       half_tick;

	assign half_tick = (half_cnt == 3'(SCLK_HALF_CYC - 1));

	// restarts on every start so the first half period is full length
	always_ff @(posedge clk or negedge rst_sync_b)
		if (!rst_sync_b)
			half_cnt <= 3'h0;
		else if (start || state == EFS_IDLE || state == EFS_HOLD || half_tick)
			half_cnt <= 3'h0;                                        // R03
		else
			half_cnt <= half_cnt + 3'h1;

	// ----------------------------------------------------------------
	// shifter and link sequencing
	// ----------------------------------------------------------------
	logic [WORD_BITS-1:0] shreg;
	logic [3:0]           bit_cnt;
	logic [2:0]           word_idx;
	logic [2:0]           hold_cnt;
	logic                 gap_half;
	logic                 word_end;
	logic [WORD_BITS-1:0] first_word;
	logic [WORD_BITS-1:0] next_word;

	assign word_end = (bit_cnt == LAST_BIT);
	// words picked once here, so their msb can be taken by a plain select
	assign first_word = efs_word(mem[rd_ptr], 3'h0);                  // R02
	assign next_word  = efs_word(cur, word_idx + 3'h1);               // R02

	always_ff @(posedge clk or negedge rst_sync_b)
		if (!rst_sync_b)
		begin
			state              <= EFS_IDLE;
			cur                <= '0;
			shreg              <= '0;
			bit_cnt            <= 4'h0;
			word_idx           <= 3'h0;
			hold_cnt           <= 3'h0;
			gap_half           <= 1'b0;
			frame_select_out_n <= 1'b1;
			stream_clock_out   <= 1'b1;
			stream_data_out    <= 1'b0;
		end
		else
		begin
			unique case (state)
				EFS_IDLE:
					if (start)
					begin
						cur                <= mem[rd_ptr];
						shreg              <= first_word;      // R02
						stream_data_out    <= first_word[WORD_BITS-1]; // R11
						word_idx           <= 3'h0;
						bit_cnt            <= 4'h0;
						frame_select_out_n <= 1'b0;
						state              <= EFS_SETUP;
					end
				EFS_SETUP, EFS_HIGH:
					if (half_tick)
					begin
						stream_clock_out <= 1'b0;          // R10
						state            <= EFS_LOW;
					end
				EFS_LOW:
					if (half_tick)
					begin
						stream_clock_out <= 1'b1;          // R03
						if (!word_end)
						begin
							shreg           <= {shreg[WORD_BITS-2:0], 1'b0};
							stream_data_out <= shreg[WORD_BITS-2]; // R07 R11
							bit_cnt         <= bit_cnt + 4'h1;
							state           <= EFS_HIGH;
						end
						else if (!per_word_select_option && word_idx != LAST_WORD)
						begin
							// select stays low, next word follows with no gap
							shreg           <= next_word;      // R02 R04
							stream_data_out <= next_word[WORD_BITS-1]; // R07
							word_idx        <= word_idx + 3'h1;
							bit_cnt         <= 4'h0;
							state           <= EFS_HIGH;
						end
						else
						begin
							hold_cnt <= 3'h0;
							state    <= EFS_HOLD;
						end
					end
				EFS_HOLD:
					// counted from the rising edge, so hold past the falling edge is longer
					if (hold_cnt == 3'(SEL_HOLD_CYC - 1))
					begin
						frame_select_out_n <= 1'b1;            // R09 R05
						gap_half           <= 1'b0;
						state <= (word_idx == LAST_WORD) ? EFS_IDLE : EFS_GAP;
					end
					else
						hold_cnt <= hold_cnt + 3'h1;
				EFS_GAP:
					// clock parked high for one full period between words
					if (half_tick)
					begin
						gap_half <= 1'b1;
						if (gap_half)
						begin
							shreg              <= next_word;       // R06
							stream_data_out    <= next_word[WORD_BITS-1];
							word_idx           <= word_idx + 3'h1;
							bit_cnt            <= 4'h0;
							frame_select_out_n <= 1'b0;        // R05
							state              <= EFS_SETUP;
						end
					end
			endcase
		end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_word_done;
		state == EFS_LOW && half_tick && word_end;
	endsequence

	sequence s_gap_entry;
		$rose(state == EFS_GAP);
	endsequence

	property p_r01;
		@(posedge clk) disable iff (!rst_sync_b)
		$fell(frame_select_out_n) && $past(state == EFS_IDLE) |->
			$past(frame_rate_sel) == RATE_128K;
	endproperty
	a_r01: assert property (p_r01) else $error("stream started off 128 kHz"); // R01

	property p_r08;
		@(posedge clk) disable iff (!rst_sync_b)
		$fell(frame_select_out_n) && $past(state == EFS_IDLE) |->
			$past(ecg_control_register[ECG_CONTROL_REGISTER_HP_BIT]);
	endproperty
	a_r08: assert property (p_r08) else $error("stream started without high performance"); // R08

	property p_r02;
		@(posedge clk) disable iff (!rst_sync_b)
		$rose(state == EFS_SETUP) && $past(state == EFS_IDLE) |->
			word_idx == 3'h0 && shreg == cur.header;
	endproperty
	a_r02: assert property (p_r02) else $error("packet did not open with header"); // R02

	property p_r03;
		@(posedge clk) disable iff (!rst_sync_b)
		$changed(stream_clock_out) |-> $past(half_tick) && $past(half_cnt) == 3'(SCLK_HALF_CYC-1);
	endproperty
	a_r03: assert property (p_r03) else $error("stream clock edge off its timebase"); // R03

	property p_r04;
		@(posedge clk) disable iff (!rst_sync_b)
		(!per_word_select_option && word_idx != LAST_WORD) and s_word_done |=>
			!frame_select_out_n && state == EFS_HIGH;
	endproperty
	a_r04: assert property (p_r04) else $error("select dropped inside packet"); // R04

	property p_r05;
		@(posedge clk) disable iff (!rst_sync_b)
		per_word_select_option and s_word_done |=> state == EFS_HOLD ##5 frame_select_out_n;
	endproperty
	a_r05: assert property (p_r05) else $error("select not released after word"); // R05

	property p_r06;
		@(posedge clk) disable iff (!rst_sync_b)
		s_gap_entry |-> (stream_clock_out && frame_select_out_n)[*4] ##1 !frame_select_out_n;
	endproperty
	a_r06: assert property (p_r06) else $error("inter-word gap not one clock period"); // R06

	property p_r07;
		@(posedge clk) disable iff (!rst_sync_b)
		$changed(stream_data_out) && !$fell(frame_select_out_n) |-> $rose(stream_clock_out);
	endproperty
	a_r07: assert property (p_r07) else $error("data changed away from rising edge"); // R07

	property p_r09;
		@(posedge clk) disable iff (!rst_sync_b)
		$rose(frame_select_out_n) |-> $past(stream_clock_out, 5) && $past(stream_clock_out, 1);
	endproperty
	a_r09: assert property (p_r09) else $error("select released too soon after last edge"); // R09

	property p_r11;
		@(posedge clk) disable iff (!rst_sync_b)
		$fell(frame_select_out_n) |-> stream_data_out == shreg[WORD_BITS-1] && bit_cnt == 4'h0;
	endproperty
	a_r11: assert property (p_r11) else $error("word did not start msb first"); // R11

endmodule : efs_stream_port

// ===== tb/efs_rx_model.sv
// receiver model for the ecg frame stream: captures words off the master link
// assumes the select is active low and the stream clock idles high
`timescale 1ns/1ns

// --------------------------------------------------------------
// far-side receiver
// --------------------------------------------------------------
module efs_rx_model (
	input wire logic frame_select_out_n,
	input wire logic stream_clock_out,
	input wire logic stream_data_out
);
	logic [15:0] sh = 16'h0000;
	int          nbit = 0;
	logic [15:0] words[$];
	int          per_sel[$];

	// sample data on the falling clock, only while selected
	always @(negedge stream_clock_out)
	begin
		if (frame_select_out_n === 1'b0)
		begin
			sh = {sh[14:0], stream_data_out};
			nbit++;
			if (nbit % 16 == 0)
				words.push_back(sh);
		end
	end

	// bits seen per select period, so the bench can tell the select modes apart
	always @(posedge frame_select_out_n)
	begin
		if (nbit > 0)
			per_sel.push_back(nbit);
		nbit = 0;
	end
endmodule : efs_rx_model

// ===== tb/tb_top.sv
// bench for the frame stream master port: random frames in, serial words out
// assumes a 100 MHz clk and a free-running 125 ns crystal reference
`timescale 1ns/1ns

module tb_top;
	import efs_pkg::*;

	logic       clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       xtal_ref = 1'b0;
	logic [7:0] ecg_control_register = 8'h00;
	logic [1:0] frame_rate_sel = 2'h0;
	logic       per_word_select_option = 1'b0;
	efs_frame_t frame_in = '0;
	logic       frame_valid = 1'b0;
	logic       frame_ready;
	logic       sel_n;
	logic       sck;
	logic       sdo;
	int         seed = 32'he2e215b2;
	int         err_total = 0;
	int         n_tests = 0;
	logic       saw_full;

	// --------------------------------------------------------------
	// clocks, design and receiver
	// --------------------------------------------------------------
	always #5 clk = ~clk;
	// odd start offset keeps the rising crystal edges out of phase with clk; the falling edges land on clk edges
	always
	begin
		#63 xtal_ref = 1'b1;
		#62 xtal_ref = 1'b0;
	end

	efs_stream_port #(.DEPTH(2)) uut (.clk(clk), .rst_b(rst_b), .xtal_ref(xtal_ref),
		.ecg_control_register(ecg_control_register), .frame_rate_sel(frame_rate_sel),
		.per_word_select_option(per_word_select_option), .frame_in(frame_in),
		.frame_valid(frame_valid), .frame_ready(frame_ready),
		.frame_select_out_n(sel_n), .stream_clock_out(sck), .stream_data_out(sdo));

	efs_rx_model rx (.frame_select_out_n(sel_n), .stream_clock_out(sck),
		.stream_data_out(sdo));

	// --------------------------------------------------------------
	// tasks
	// --------------------------------------------------------------
	task chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("unexpected %s: expected %h seen %h", what, e, g);
			err_total++;
		end
	endtask : chk

	// hold valid until ready is seen high at a falling edge, then one rising edge more
	task send(input efs_frame_t f);
		logic r;
		int   w;
		w = 0;
		@(posedge clk);
		frame_in <= f;
		frame_valid <= 1'b1;
		do
		begin
			@(negedge clk);
			r = frame_ready;
			if (r !== 1'b1)
				saw_full = 1'b1;
			@(posedge clk);
			w++;
		end while (r !== 1'b1 && w < 3000);
		frame_valid <= 1'b0;
	endtask : send

	task run(input logic opt, input logic hp, input logic [1:0] rate, input int n);
		logic [127:0] r;
		efs_frame_t   f;
		logic [15:0]  exp_q[$];
		int           i;
		int           k;
		saw_full = 1'b0;
		exp_q.delete();
		rx.words.delete();
		rx.per_sel.delete();
		@(posedge clk);
		per_word_select_option <= opt;
		ecg_control_register <= {4'h0, hp, 3'h0};
		frame_rate_sel <= rate;
		for (i = 0; i < n; i++)
		begin
			r = {$random(seed), $random(seed), $random(seed), $random(seed)};
			f = r[111:0];
			if (hp && rate == RATE_128K)
			begin
				exp_q.push_back(f.header);
				for (k = 0; k < 5; k++)
					exp_q.push_back(f.ecg[k]);
				exp_q.push_back(f.crc);
			end
			send(f);
		end
		k = 0;
		while (rx.words.size() < exp_q.size() && k < 6000)
		begin
			@(posedge clk);
			k++;
		end
		// two frame ticks more so any dropped or stray frame would show
		repeat (1700) @(posedge clk);
		chk("word count", 16'(exp_q.size()), 16'(rx.words.size()));
		for (i = 0; i < exp_q.size(); i++)
			chk("serial word", exp_q[i], rx.words[i]);
		k = (exp_q.size() == 0) ? 0 : (opt ? 7 * n : n);
		chk("select periods", 16'(k), 16'(rx.per_sel.size()));
		for (i = 0; i < rx.per_sel.size(); i++)
			chk("bits per select", opt ? 16'h0010 : 16'h0070, 16'(rx.per_sel[i]));
		if (n > 2)
			chk("buffer full seen", 16'h0001, {15'h0000, saw_full});
		$display("test end: option %0d hp %0d rate %0d frames %0d", opt, hp, rate, n);
	endtask : run

	task end_sim;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim

	// --------------------------------------------------------------
	// sequence and watchdog
	// --------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		run(1'b0, 1'b1, RATE_128K, 3);
		run(1'b1, 1'b1, RATE_128K, 3);
		run(1'b1, 1'b0, RATE_128K, 1);
		run(1'b0, 1'b1, RATE_16K, 1);
		run(1'b1, 1'b1, RATE_2K, 1);
		end_sim();
	end

	// roughly four times the expected run length
	initial
	begin
		repeat (60000) @(posedge clk);
		err_total++;
		end_sim();
	end
endmodule : tb_top
